// ===== ictr_edge.sv
`timescale 1ns/1ps
// Edge detector for one synchronised interrupt input with selectable polarity.
module ictr_edge (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_level,
  input wire logic i_falling_sel,
  output logic o_pulse
);

  // The previous sample is all the state this detector needs.
  typedef struct packed {
    logic prev;
  } ictr_edge_state_type;

  ictr_edge_state_type state_reg; // Registered previous level.
  ictr_edge_state_type state_next; // Next previous level.

  // Remember the level for the comparison in the next cycle.
  always_comb
  begin
    state_next.prev = i_level;
  end

  // The previous level clears under reset.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // One selects the falling edge, zero the rising edge; the pulse lasts one cycle.
  assign o_pulse = i_falling_sel ? (state_reg.prev & ~i_level) : (~state_reg.prev & i_level);

endmodule

// ===== ictr_pin_model.sv
`timescale 1ns/1ps
// Far-side model of the interrupt pins and the timed-disable status source.
module ictr_pin_model (
  input wire logic i_clock,
  input wire logic [2:0] i_pin_cmd,
  input wire logic i_timed_irq_disable_active_cmd,
  output logic [2:0] o_ext_irq,
  output logic o_timed_irq_disable_active
);
  // Pins move 3 ns after a command, with no phase tie to the clock.
  // both edges offered
  always @(i_pin_cmd) o_ext_irq <= #3 i_pin_cmd;
  always @(posedge i_clock) o_timed_irq_disable_active <= i_timed_irq_disable_active_cmd;
  // Both lines start low, so reset release shows no edge.
  initial o_ext_irq = 3'h0;
  initial o_timed_irq_disable_active = 1'b0;
endmodule

// ===== ictr_pkg.sv
// Shared constants for the interrupt control two register block.
package ictr_pkg;
  // APB data width and the address width that the slave decodes.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // Number of external interrupt inputs handled here.
  localparam int unsigned NUM_EXT_IRQ = 3;
  // Byte address of the control register on the APB.
  localparam logic [7:0] CTRL_TWO_OFFSET = 8'h00;
  // Field positions inside the control register.
  localparam int unsigned ALT_VT_BIT = 15;
  localparam int unsigned TIMED_IRQ_DISABLE_ACTIVE_BIT = 14;
  localparam int unsigned UNIMPL_MSB = 13;
  localparam int unsigned UNIMPL_LSB = 3;
  localparam int unsigned POL_LSB = 0;
  // Byte lanes that carry the writable fields.
  localparam int unsigned ALT_VT_LANE = 1;
  localparam int unsigned POL_LANE = 0;
  // Reset values of the writable fields and of the read data bus.
  localparam logic ALT_VT_RESET = 1'b0;
  localparam logic POL_RESET = 1'b0;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
endpackage

// ===== ictr_regs.sv
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// (RULE1) Bit 15 one selects alternate vector table.
// (RULE2) Bit 14 reads one while timed disable active.
// (RULE3) Bits 13 to 3 read zero, ignore writes.
// (RULE4) Edge select one means falling, zero rising.
// (RULE5) Bit 2 selects edge for input two.
// (RULE6) Bit 1 selects edge for input one.
// (RULE7) Bit 0 selects edge for input zero.
// (RULE8) Synchronise inputs, pulse once per selected edge.
module ictr_regs #(
  parameter int unsigned NUM_IRQ = ictr_pkg::NUM_EXT_IRQ,
  parameter int unsigned ADDR_W = ictr_pkg::ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_timed_irq_disable_active,
  input wire logic [NUM_IRQ-1:0] i_ext_irq,
  output logic o_alt_vector_table_select,
  output logic [NUM_IRQ-1:0] o_ext_irq_req
);

  // Bus handshake phases: idle until a setup cycle, then one answering cycle.
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } ictr_bus_type;

  // All state of this module outside the synchroniser and edge detectors lives in one packed record.
  typedef struct packed {
    ictr_bus_type bus;
    logic alt_vt;
    logic [NUM_IRQ-1:0] pol;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [NUM_IRQ-1:0] irq_req;
  } ictr_state_type;

  // Values taken under reset: standard table, rising edges, bus quiet.
  localparam ictr_state_type STATE_RESET = '{
    bus: BUS_IDLE,
    alt_vt: ictr_pkg::ALT_VT_RESET,
    pol: {NUM_IRQ{ictr_pkg::POL_RESET}},
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: ictr_pkg::RDATA_IDLE,
    irq_req: '0
  };

  ictr_state_type state_reg; // Registered state.
  ictr_state_type state_next; // Next state.
  logic [NUM_IRQ-1:0] sync_q; // Pins after the synchroniser.
  logic [NUM_IRQ-1:0] edge_pulse; // Raw edge hits, one per input.

  // Pins come from outside the clock domain, so they pass two stages first.
  // (RULE8) synchronise external inputs
  ictr_sync #(
    .WIDTH(NUM_IRQ)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async(i_ext_irq),
    .o_sync(sync_q)
  );

  // One edge detector per input, steered by its own polarity bit.
  // (RULE4) per input edge choice
  for (genvar k = 0; k < NUM_IRQ; k++)
  begin : g_edge
    ictr_edge u_edge (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_level(sync_q[k]),
      .i_falling_sel(state_reg.pol[k]),
      .o_pulse(edge_pulse[k])
    );
  end

  // Next-state logic for the bus slave, the register and the request pulses.
  always_comb
  begin
    logic [31:0] read_word;
    logic hit;
    read_word = ictr_pkg::RDATA_IDLE;
    hit = (i_paddr == ictr_pkg::CTRL_TWO_OFFSET[ADDR_W-1:0]);
    state_next = state_reg;
    // (RULE1) report table select
    read_word[ictr_pkg::ALT_VT_BIT] = state_reg.alt_vt;
    // (RULE2) report timed disable
    read_word[ictr_pkg::TIMED_IRQ_DISABLE_ACTIVE_BIT] = i_timed_irq_disable_active;
    // (RULE5) polarity field readback
    read_word[ictr_pkg::POL_LSB +: NUM_IRQ] = state_reg.pol;
    // The detectors are combinational, so the pulse is registered here.
    // (RULE8) one cycle request
    state_next.irq_req = edge_pulse;
    case (state_reg.bus)
      BUS_IDLE:
      begin
        // A setup cycle is answered in the next cycle, with no wait states.
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.prdata = ictr_pkg::RDATA_IDLE;
        if (i_psel && !i_penable)
        begin
          // Read data is captured at setup; the field cannot change before the access edge
          // except the timed-disable status, which is a live level anyway.
          state_next.pready = 1'b1;
          state_next.pslverr = !hit;
          // (RULE3) unimplemented bits zero
          state_next.prdata = hit ? read_word : ictr_pkg::RDATA_IDLE;
          state_next.bus = BUS_ANSWER;
        end
      end
      BUS_ANSWER:
      begin
        // The access edge is now: the master samples pready high here.
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.prdata = ictr_pkg::RDATA_IDLE;
        state_next.bus = BUS_IDLE;
        if (i_psel && i_penable && i_pwrite && !state_reg.pslverr)
        begin
          // Only the implemented bits are stored; bits 13 to 3 and 14 drop.
          // (RULE3) writes to unimplemented ignored
          if (i_pstrb[ictr_pkg::ALT_VT_LANE])
          begin
            // (RULE1) store table select
            state_next.alt_vt = i_pwdata[ictr_pkg::ALT_VT_BIT];
          end
          if (i_pstrb[ictr_pkg::POL_LANE])
          begin
            // (RULE6) store edge polarities
            state_next.pol = i_pwdata[ictr_pkg::POL_LSB +: NUM_IRQ];
          end
        end
      end
      default:
      begin
        // An illegal code returns the bus to idle with a quiet answer.
        state_next.bus = BUS_IDLE;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.prdata = ictr_pkg::RDATA_IDLE;
      end
    endcase
  end

  // The register stage of the record; the synchroniser and edge detectors hold their own.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Every output is taken straight from the registered state.
  assign o_pready = state_reg.pready;
  assign o_prdata = state_reg.prdata;
  assign o_pslverr = state_reg.pslverr;
  // (RULE1) drive table select
  assign o_alt_vector_table_select = state_reg.alt_vt;
  // (RULE7) drive edge requests
  assign o_ext_irq_req = state_reg.irq_req;

  // All checks below run on the one clock and stop under reset.
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  // A completed write of bit 15 reaches the table select the next cycle.
  a_alt_vt_write: assert property ( // (RULE1)
    (i_psel && i_penable && o_pready && i_pwrite && !o_pslverr && i_pstrb[ictr_pkg::ALT_VT_LANE])
    |=> (o_alt_vector_table_select == $past(i_pwdata[ictr_pkg::ALT_VT_BIT])))
    else $error("Table select did not follow the write.");

  // A read of the register shows the timed disable level seen at setup.
  a_timed_irq_disable_active_readback: assert property ( // (RULE2)
    (state_reg.bus == BUS_IDLE && i_psel && !i_penable
     && i_paddr == ictr_pkg::CTRL_TWO_OFFSET[ADDR_W-1:0])
    |=> (o_pready && o_prdata[ictr_pkg::TIMED_IRQ_DISABLE_ACTIVE_BIT] == $past(i_timed_irq_disable_active)))
    else $error("Timed disable status read back wrong.");

  // Unimplemented bits are always zero on the read bus.
  a_unimpl_zero: assert property ( // (RULE3)
    o_prdata[ictr_pkg::UNIMPL_MSB:ictr_pkg::UNIMPL_LSB] == '0)
    else $error("Unimplemented bits read as one.");

  // A falling edge on input zero with rising selected raises nothing.
  a_wrong_edge_quiet: assert property ( // (RULE4)
    ($fell(sync_q[0]) && !state_reg.pol[0]) |=> !o_ext_irq_req[0])
    else $error("Request raised on the unselected edge.");

  // Input two with falling selected requests after a falling edge.
  a_irq2_falling: assert property ( // (RULE5)
    ($fell(sync_q[2]) && state_reg.pol[2]) |=> o_ext_irq_req[2])
    else $error("Input two missed its falling edge.");

  // Input one with rising selected requests after a rising edge.
  a_irq1_rising: assert property ( // (RULE6)
    ($rose(sync_q[1]) && !state_reg.pol[1]) |=> o_ext_irq_req[1])
    else $error("Input one missed its rising edge.");

  // Input zero with rising selected requests after a rising edge.
  a_irq0_rising: assert property ( // (RULE7)
    ($rose(sync_q[0]) && !state_reg.pol[0]) |=> o_ext_irq_req[0])
    else $error("Input zero missed its rising edge.");

  // With no change on any synchronised input, no request follows.
  a_no_change_quiet: assert property ( // (RULE8)
    ($stable(sync_q) ##1 $stable(sync_q)) |=> (o_ext_irq_req == '0))
    else $error("Request raised without an edge.");

endmodule

// ===== ictr_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of asynchronous levels.
module ictr_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // The first stage may go metastable, so only the second stage reads it.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ictr_sync_state_type;

  ictr_sync_state_type state_reg; // Registered stages.
  ictr_sync_state_type state_next; // Next value of the stages.

  // Shift the pins through the two stages.
  always_comb
  begin
    state_next.meta = i_async;
    state_next.stable = state_reg.meta;
  end

  // Both stages clear under reset.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Only the second stage leaves the module.
  assign o_sync = state_reg.stable;

endmodule

// ===== interrupt_control_two_register_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt control two register block.
module interrupt_control_two_register_bench;
  logic i_clock, i_rst_b, psel, pen, pwr, pready, perr, alt, timed_irq_disable_active_cmd, timed_irq_disable_active, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] pin_cmd, pins, req;
  int failures, n_compared;
  int hi_cnt [3];

  ictr_regs uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(perr), .i_timed_irq_disable_active(timed_irq_disable_active), .i_ext_irq(pins),
    .o_alt_vector_table_select(alt), .o_ext_irq_req(req));
  ictr_pin_model pm (.i_clock(i_clock), .i_pin_cmd(pin_cmd), .i_timed_irq_disable_active_cmd(timed_irq_disable_active_cmd), .o_ext_irq(pins),
    .o_timed_irq_disable_active(timed_irq_disable_active));

  // A 10 ns clock.
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Counts high cycles per request line; a clean pulse adds exactly one.
  always @(posedge i_clock)
    for (int k = 0; k < 3; k++)
      if (req[k] === 1'b1) hi_cnt[k]++;

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the wait is bounded so a dead slave cannot hang us.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge i_clock);
    pen <= 1'b1;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = perr;
    psel <= 1'b0; pen <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1, "pready never came");
  endtask

  // Reset values: everything reads zero.
  task t_reset;
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h0, "reset read");
    chk(alt, 1'b0, "reset table select");
    $display("t_reset done");
  endtask

  // Writes, byte lanes, read-only status bit and unimplemented bits.
  task t_write;
    apb(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
    @(posedge i_clock);
    #1 chk(alt, 1'b1, "alt table selected");
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h0000_8007, "all ones readback");
    timed_irq_disable_active_cmd <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h0000_c007, "disable active");
    timed_irq_disable_active_cmd <= 1'b0;
    apb(1'b1, 8'h00, 32'h0, 4'h1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h0000_8000, "lane0 only");
    apb(1'b1, 8'h00, 32'h0, 4'h2);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h0, "lane1 clears alt");
    #1 chk(alt, 1'b0, "standard table");
    $display("t_write done");
  endtask

  // Unmapped address answers with an error and changes nothing.
  task t_unmapped;
    apb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    chk(err, 1'b1, "unmapped write err");
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk(err, 1'b1, "unmapped read err");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(err, 1'b0, "mapped read err");
    chk(rd, 32'h0, "register untouched");
    $display("t_unmapped done");
  endtask

  // Each input, each polarity: one pulse on the chosen edge, none elsewhere.
  task t_edges;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 3; i++)
      begin
        apb(1'b1, 8'h00, p ? 32'h7 : 32'h0, 4'hf);
        #1 hi_cnt = '{0, 0, 0};
        pin_cmd[i] <= 1'b1;
        repeat (8) @(posedge i_clock);
        chk(hi_cnt[i], p ? 0 : 1, "after rise");
        pin_cmd[i] <= 1'b0;
        repeat (8) @(posedge i_clock);
        chk(hi_cnt[i], 1, "after fall");
        chk(hi_cnt[0] + hi_cnt[1] + hi_cnt[2], 1, "other lines");
      end
    $display("t_edges done");
  endtask

  // Prints the counts and the verdict, then stops.
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence; reset held for three cycles.
  initial
  begin
    i_rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pstrb = 4'h0; pin_cmd = 3'h0; timed_irq_disable_active_cmd = 1'b0;
    failures = 0; n_compared = 0; hi_cnt = '{0, 0, 0};
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_reset;
    t_write;
    t_unmapped;
    t_edges;
    give_verdict;
  end

  // The tests need well under 1000 cycles; 10000 means a hang.
  initial
  begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule
